// ===== saq_acquire_ctrl.v
// acquisition control for four simultaneous 24-bit inputs
// Summary of operation
// - four single-ended inputs 0..3 latched together on one sample edge
// - host picks gain 1 or 10, spans ten volts or one volt
// - per-input 4 mA excitation enable, off after reset
// - per-input coupling; DC after reset, AC on second extended variant
// - every result is 24 bits wide, fixed
// - requested rate 195.3 Hz..52.734 kHz, or 105.469 kHz on variant B
// - oscillator is rate times 512, or 256 above 52.734 kHz
// - derived timebase never above 27 MHz
// - first result valid only after 39 sample pulses
// - tachometer held back in scans to align with delayed analog samples
// - host can read back the achieved sample rate
// - one sample clock paces input and output once started
// - single-value mode converts one chosen channel and returns at once
// - single-value accepts channels 0..3 only
// - single-values samples all inputs at one gain, one array
// - base variant single-values carries valid tach 0 as slot 4
// - extended variants add tach, gate, readback slots; only 0..3 valid
// - single operations end by themselves, no stop needed
// - scan list holds up to five entries on base, tach 0 at slot 4
`include "saq_regs.vh"
`default_nettype none
module saq_acquire_ctrl (
	input  wire        clk_in,
	input  wire        reset_n_in,
	input  wire [1:0]  variant_in,
	input  wire        gain_ten_in,
	input  wire [3:0]  excite_set_in,
	input  wire [3:0]  couple_ac_set_in,
	input  wire        iepe_load_in,
	input  wire [27:0] rate_req_in,
	input  wire        rate_load_in,
	input  wire        clock_start_in,
	input  wire        clock_stop_in,
	input  wire        single_go_in,
	input  wire [2:0]  single_chan_in,
	input  wire        multi_go_in,
	input  wire [2:0]  scan_len_in,
	input  wire        scan_go_in,
	input  wire [95:0] adc_data_in,
	input  wire [23:0] tach0_in,
	input  wire [23:0] tach1_in,
	input  wire [23:0] gate_in,
	input  wire [23:0] aout_rb_in,
	output reg         gain_ten_out,
	output reg  [3:0]  excite_en_out,
	output reg  [3:0]  couple_ac_out,
	output reg  [25:0] osc_hz_out,
	output reg  [27:0] rate_act_out,
	output reg         rate_clamped_out,
	output reg         sample_tick_out,
	output reg         clock_run_out,
	output reg         data_valid_out,
	output reg         single_done_out,
	output reg         single_err_out,
	output reg  [23:0] single_data_out,
	output reg         multi_done_out,
	output reg  [191:0] multi_data_out,
	output reg  [7:0]  multi_valid_out,
	output wire [26:0] stream_data_out,
	output wire        stream_valid_out,
	input  wire        stream_ready_in,
	output wire        overrun_out
);
	reg         boot_reg;
	reg [31:0]  acc_reg;
	reg [31:0]  step_reg;
	reg [5:0]   delay_cnt_reg;
	reg [23:0]  tach_pipe [0:38];
	reg [23:0]  samp_reg [0:4];
	reg [2:0]   slot_reg;
	reg [2:0]   len_reg;
	reg         emit_reg;
	reg         overrun_reg;
	wire        fifo_ready;
	wire [27:0] rate_lim;
	wire [27:0] rate_top;
	wire        rate_hi;
	wire [26:0] fifo_wdata;
	integer     i;

	// pick one 24-bit lane from the packed converter bus
	function [23:0] lane;
		input [95:0] bus;
		input [1:0]  idx;
		begin
			lane = bus[idx*24 +: 24];
		end
	endfunction

	// rate times multiplier, millihertz in, hertz out
	function [25:0] osc_of;
		input [27:0] r;
		input        high;
		reg   [37:0] p;
		reg   [37:0] q;
		begin
			p = high ? ({10'd0, r} * 38'd256) : ({10'd0, r} * 38'd512);
			q = p / 38'd1000;
			// top rate of variant B lands 64 hertz over the limit
			osc_of = (q > {12'd0, `SAQ_TB_MAX_HZ}) ?
				`SAQ_TB_MAX_HZ : q[25:0];
		end
	endfunction

	// variant B reaches the higher ceiling
	assign rate_top = (variant_in == `SAQ_VAR_EXT_B) ?
		`SAQ_RATE_MAX_MHZ : `SAQ_RATE_MID_MHZ;
	assign rate_lim = (rate_req_in < `SAQ_RATE_MIN_MHZ) ? `SAQ_RATE_MIN_MHZ :
		(rate_req_in > rate_top) ? rate_top : rate_req_in;
	assign rate_hi = (rate_lim > `SAQ_RATE_MID_MHZ);

	// iepe and gain settings; coupling default depends on variant
	always @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			gain_ten_out  <= 1'b0;
			excite_en_out <= 4'h0;
			couple_ac_out <= 4'h0;
		end else if (iepe_load_in) begin
			gain_ten_out  <= gain_ten_in;
			excite_en_out <= excite_set_in;
			couple_ac_out <= couple_ac_set_in;
		end else if (boot_reg) begin
			// variant B wakes up AC coupled; variant is a live strap
			couple_ac_out <= (variant_in == `SAQ_VAR_EXT_B) ?
				4'hF : 4'h0;
		end
	end

	// first cycle after release applies the variant coupling default
	always @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			boot_reg <= 1'b1;
		end else begin
			boot_reg <= 1'b0;
		end
	end

	// rate setup: clamp, multiplier, phase step for the divider
	always @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			rate_act_out     <= `SAQ_RATE_MIN_MHZ;
			osc_hz_out       <= 26'h000_0000;
			rate_clamped_out <= 1'b0;
			step_reg         <= 32'h0000_0000;
		end else if (rate_load_in) begin
			osc_hz_out <= osc_of(rate_lim, rate_hi);
			rate_clamped_out <= (rate_lim != rate_req_in);
			// step = rate/clk * 2^32, rate in mHz; granularity shows here
			step_reg <= step_calc(rate_lim, rate_hi);
			rate_act_out <= act_calc(step_calc(rate_lim, rate_hi));
		end
	end

	function [31:0] step_calc;
		input [27:0] r;
		input        high;
		reg   [63:0] t;
		begin
			// round up low rates, down high ones: achieved rate stays in range
			t = (({36'd0, r} << 32) +
				(high ? 64'd0 : 64'd19999999999)) / 64'd20000000000;
			step_calc = t[31:0];
		end
	endfunction

	// achieved rate back in millihertz from the quantised step
	function [27:0] act_calc;
		input [31:0] s;
		reg   [63:0] t;
		begin
			t = ({32'd0, s} * 64'd20000000000) >> 32;
			act_calc = t[27:0];
		end
	endfunction

	// run control and phase accumulator sample clock
	always @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			clock_run_out   <= 1'b0;
			acc_reg         <= 32'h0000_0000;
			sample_tick_out <= 1'b0;
		end else begin
			if (clock_stop_in) begin
				clock_run_out <= 1'b0;
			end else if (clock_start_in) begin
				clock_run_out <= 1'b1;
			end
			sample_tick_out <= 1'b0;
			if (clock_run_out) begin
				{sample_tick_out, acc_reg} <=
					{1'b0, acc_reg} + {1'b0, step_reg};
			end else begin
				acc_reg <= 32'h0000_0000;
			end
		end
	end

	// group delay count, data valid after the 39th pulse
	always @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			delay_cnt_reg  <= 6'd0;
			data_valid_out <= 1'b0;
		end else if (!clock_run_out) begin
			delay_cnt_reg  <= 6'd0;
			data_valid_out <= 1'b0;
		end else if (sample_tick_out && !data_valid_out) begin
			delay_cnt_reg <= delay_cnt_reg + 6'd1;
			if (delay_cnt_reg == `SAQ_GROUP_DELAY - 6'd1) begin
				data_valid_out <= 1'b1;
			end
		end
	end

	// tachometer delay line, matched to converter group delay
	always @(posedge clk_in) begin
		if (sample_tick_out) begin
			tach_pipe[0] <= tach0_in;
			for (i = 1; i < 39; i = i + 1) begin
				tach_pipe[i] <= tach_pipe[i-1];
			end
		end
	end

	// single-value and single-values, finished in one cycle
	always @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			single_done_out <= 1'b0;
			single_err_out  <= 1'b0;
			single_data_out <= 24'h00_0000;
			multi_done_out  <= 1'b0;
			multi_data_out  <= 192'h0;
			multi_valid_out <= 8'h00;
		end else begin
			single_done_out <= 1'b0;
			multi_done_out  <= 1'b0;
			if (single_go_in) begin
				single_done_out <= 1'b1;
				single_err_out  <= single_chan_in[2];
				single_data_out <= single_chan_in[2] ? 24'h00_0000 :
					lane(adc_data_in, single_chan_in[1:0]);
			end
			if (multi_go_in) begin
				multi_done_out <= 1'b1;
				multi_data_out <= {aout_rb_in, gate_in, tach1_in,
					tach0_in, adc_data_in};
				multi_valid_out <= (variant_in == `SAQ_VAR_BASE) ?
					8'h1F : 8'h0F;
			end
		end
	end

	// scan sequencer: latch all inputs on one tick, emit list entries
	always @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			slot_reg    <= 3'd0;
			len_reg     <= 3'd5;
			emit_reg    <= 1'b0;
			overrun_reg <= 1'b0;
		end else begin
			if (scan_go_in) begin
				len_reg <= (scan_len_in == 3'd0 || scan_len_in > 3'd5) ?
					3'd5 : scan_len_in;
				overrun_reg <= 1'b0;
			end
			if (sample_tick_out && data_valid_out && clock_run_out) begin
				if (emit_reg) begin
					overrun_reg <= 1'b1; // still draining last scan
				end
				emit_reg <= 1'b1;
				slot_reg <= 3'd0;
			end else if (emit_reg && fifo_ready) begin
				if (slot_reg == len_reg - 3'd1) begin
					emit_reg <= 1'b0;
				end
				slot_reg <= slot_reg + 3'd1;
			end
		end
	end

	// simultaneous capture of all four lanes plus delayed tach
	always @(posedge clk_in) begin
		if (sample_tick_out) begin
			for (i = 0; i < 4; i = i + 1) begin
				samp_reg[i] <= lane(adc_data_in, i[1:0]);
			end
			samp_reg[4] <= tach_pipe[38];
		end
	end

	assign fifo_wdata  = {slot_reg, samp_reg[slot_reg]};
	assign overrun_out = overrun_reg;

	// output stream buffer, drain side can stall the sequencer
	saq_fifo #(
		.WIDTH (`SAQ_FIFO_W),
		.DEPTH (`SAQ_FIFO_D),
		.AW    (`SAQ_FIFO_AW)
	) u_fifo (
		.clk_in       (clk_in),
		.reset_n_in   (reset_n_in),
		.wr_data_in   (fifo_wdata),
		.wr_valid_in  (emit_reg),
		.wr_ready_out (fifo_ready),
		.rd_data_out  (stream_data_out),
		.rd_valid_out (stream_valid_out),
		.rd_ready_in  (stream_ready_in)
	);
endmodule // saq_acquire_ctrl
`default_nettype wire

// ===== saq_regs.vh
// constants for the simultaneous acquisition control block
`ifndef SAQ_REGS_VH
`define SAQ_REGS_VH
`define SAQ_NUM_CH        3'd4
`define SAQ_SAMPLE_W      24
`define SAQ_SLOT_W        3
`define SAQ_SLOT_TACH0    3'd4
`define SAQ_SLOT_TACH1    3'd5
`define SAQ_SLOT_GATE     3'd6
`define SAQ_SLOT_AOUT     3'd7
`define SAQ_GROUP_DELAY   6'd39
`define SAQ_MUL_LOW       10'd512
`define SAQ_MUL_HIGH      10'd256
// rates in millihertz
`define SAQ_RATE_W        28
`define SAQ_RATE_MIN_MHZ  28'd195300
`define SAQ_RATE_MID_MHZ  28'd52734000
`define SAQ_RATE_MAX_MHZ  28'd105469000
// timebase in hertz
`define SAQ_TB_W          26
`define SAQ_TB_MAX_HZ     26'd27000000
// internal reference for divider, 20 MHz clock in hertz
`define SAQ_CLK_HZ        26'd20000000
`define SAQ_FIFO_W        27
`define SAQ_FIFO_D        16
`define SAQ_FIFO_AW       4
`define SAQ_VAR_BASE      2'd0
`define SAQ_VAR_EXT_A     2'd1
`define SAQ_VAR_EXT_B     2'd2
`define SAQ_ACCUM_W       32
`endif

// ===== saq_fifo.v
// parameterised fifo with valid and ready on both sides
`default_nettype none
module saq_fifo #(
	parameter WIDTH = 27,
	parameter DEPTH = 16,
	parameter AW    = 4
) (
	input  wire             clk_in,
	input  wire             reset_n_in,
	input  wire [WIDTH-1:0] wr_data_in,
	input  wire             wr_valid_in,
	output wire             wr_ready_out,
	output reg  [WIDTH-1:0] rd_data_out,
	output wire             rd_valid_out,
	input  wire             rd_ready_in
);
	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW:0]      wptr_reg;
	reg [AW:0]      rptr_reg;
	wire            empty;
	wire            full;
	wire            do_wr;
	wire            do_rd;
	// extra pointer bit tells full from empty
	assign empty = (wptr_reg == rptr_reg);
	assign full  = (wptr_reg[AW] != rptr_reg[AW]) &&
		(wptr_reg[AW-1:0] == rptr_reg[AW-1:0]);
	assign wr_ready_out = !full;
	assign rd_valid_out = !empty;
	assign do_wr = wr_valid_in && !full;
	assign do_rd = rd_ready_in && !empty;
	// storage write
	always @(posedge clk_in) begin
		if (do_wr) begin
			mem[wptr_reg[AW-1:0]] <= wr_data_in;
		end
	end
	// head word read combinationally from the read pointer
	always @* begin
		rd_data_out = mem[rptr_reg[AW-1:0]];
	end
	// pointers
	always @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			wptr_reg <= {(AW+1){1'b0}};
			rptr_reg <= {(AW+1){1'b0}};
		end else begin
			if (do_wr) begin
				wptr_reg <= wptr_reg + {{AW{1'b0}}, 1'b1};
			end
			if (do_rd) begin
				rptr_reg <= rptr_reg + {{AW{1'b0}}, 1'b1};
			end
		end
	end
endmodule // saq_fifo
`default_nettype wire

// ===== saq_acq_props.sv
// assertion checker for the acquisition control block
`include "saq_regs.vh"
`default_nettype none
module saq_acq_props (
	input wire logic        clk_in,
	input wire logic        reset_n_in,
	input wire logic [1:0]  variant_in,
	input wire logic        iepe_load_in,
	input wire logic [3:0]  excite_set_in,
	input wire logic        single_go_in,
	input wire logic [2:0]  single_chan_in,
	input wire logic        multi_go_in,
	input wire logic [3:0]  excite_en_out,
	input wire logic [25:0] osc_hz_out,
	input wire logic [27:0] rate_act_out,
	input wire logic        sample_tick_out,
	input wire logic        clock_run_out,
	input wire logic        data_valid_out,
	input wire logic        single_done_out,
	input wire logic        single_err_out,
	input wire logic [23:0] single_data_out,
	input wire logic        multi_done_out,
	input wire logic [7:0]  multi_valid_out
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!reset_n_in);
	logic [5:0] tick_cnt_reg;
	// ticks since start; saturates so a long run never wraps to zero
	always_ff @(posedge clk_in or negedge reset_n_in)
		if (!reset_n_in)
			tick_cnt_reg <= 6'h00;
		else if (!clock_run_out)
			tick_cnt_reg <= 6'h00;
		else if (sample_tick_out && tick_cnt_reg != 6'h27)
			tick_cnt_reg <= tick_cnt_reg + 6'h01;
	// a one-cycle completion pulse
	sequence s_single_end;
		single_done_out ##1 !single_done_out;
	endsequence
	sequence s_multi_end;
		multi_done_out ##1 !multi_done_out;
	endsequence
	AST_SINGLE_DONE: assert property (single_go_in |=> s_single_end)
		else $error("single done pulse missing");
	AST_SINGLE_REFUSE: assert property (single_go_in && single_chan_in[2]
		|=> single_err_out && single_data_out == 24'h00_0000)
		else $error("channel above three not refused");
	AST_SINGLE_OK: assert property (single_go_in && !single_chan_in[2]
		|=> !single_err_out) else $error("input channel refused");
	AST_MULTI_MASK: assert property (multi_go_in |=> (multi_valid_out ==
		($past(variant_in) == 2'h0 ? 8'h1F : 8'h0F)) ##0 s_multi_end)
		else $error("array valid mask wrong");
	AST_EXCITE_LOAD: assert property (iepe_load_in
		|=> excite_en_out == $past(excite_set_in))
		else $error("excitation enable not loaded");
	AST_OSC_MAX: assert property (osc_hz_out <= `SAQ_TB_MAX_HZ)
		else $error("timebase above limit");
	AST_RATE_RANGE: assert property (rate_act_out >= `SAQ_RATE_MIN_MHZ &&
		rate_act_out <= `SAQ_RATE_MAX_MHZ) else $error("rate out of range");
	AST_VALID_LATE: assert property (data_valid_out && clock_run_out
		|-> tick_cnt_reg == 6'h27) else $error("data valid too early");
	AST_TICK_STOP: assert property (!clock_run_out ##1 !clock_run_out
		|-> !sample_tick_out) else $error("tick while stopped");
endmodule // saq_acq_props
`default_nettype wire

// ===== saq_host_model.sv
// host-side model: converter and counter source, stream sink
`default_nettype none
module saq_host_model (
	input  wire logic        clk_in,
	input  wire logic        reset_n_in,
	input  wire logic        sample_tick_in,
	input  wire logic        stall_in,
	input  wire logic [26:0] stream_data_in,
	input  wire logic        stream_valid_in,
	output logic             stream_ready_out,
	output logic [95:0]      adc_data_out,
	output logic [23:0]      tach0_out
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [15:0] cnt_reg;
	logic [26:0] rx_q[$];
	// lane k carries its index and the tick count, tach tags itself 40
	assign adc_data_out = {8'h03, cnt_reg, 8'h02, cnt_reg,
		8'h01, cnt_reg, 8'h00, cnt_reg};
	assign tach0_out = {8'h40, cnt_reg};
	assign stream_ready_out = !stall_in; // slow host simply stalls
	always @(posedge clk_in or negedge reset_n_in)
		if (!reset_n_in)
			cnt_reg <= 16'h0000;
		else if (sample_tick_in)
			cnt_reg <= cnt_reg + 16'h0001;
	// a word is taken at each edge where valid and ready meet
	always @(posedge clk_in)
		if (stream_valid_in && stream_ready_out)
			rx_q.push_back(stream_data_in);
endmodule // saq_host_model
`default_nettype wire

// ===== saq_tb.sv
// self-checking bench for the acquisition control block
`include "saq_regs.vh"
`default_nettype none
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_in, reset_n_in, gain_ten_in, iepe_load_in, rate_load_in, stall;
	logic clock_start_in, clock_stop_in, single_go_in, multi_go_in, scan_go_in;
	logic [1:0]   variant_in;
	logic [3:0]   excite_set_in, couple_ac_set_in, excite_en_out, couple_ac_out;
	logic [27:0]  rate_req_in, rate_act_out;
	logic [2:0]   single_chan_in, scan_len_in;
	logic [95:0]  adc_data;
	logic [23:0]  tach0, single_data_out;
	logic [25:0]  osc_hz_out;
	logic [191:0] multi_data_out;
	logic [7:0]   multi_valid_out;
	logic [26:0]  stream_data_out;
	logic gain_ten_out, rate_clamped_out, sample_tick_out, clock_run_out;
	logic data_valid_out, single_done_out, single_err_out, multi_done_out;
	logic stream_valid_out, stream_ready, overrun_out;
	int err_total, compares, n, k;
	saq_acquire_ctrl dut (.clk_in, .reset_n_in, .variant_in, .gain_ten_in,
		.excite_set_in, .couple_ac_set_in, .iepe_load_in, .rate_req_in,
		.rate_load_in, .clock_start_in, .clock_stop_in, .single_go_in,
		.single_chan_in, .multi_go_in, .scan_len_in, .scan_go_in,
		.adc_data_in(adc_data), .tach0_in(tach0), .tach1_in(24'h00_1111),
		.gate_in(24'h00_2222), .aout_rb_in(24'h00_3333), .gain_ten_out,
		.excite_en_out, .couple_ac_out, .osc_hz_out, .rate_act_out,
		.rate_clamped_out, .sample_tick_out, .clock_run_out, .data_valid_out,
		.single_done_out, .single_err_out, .single_data_out, .multi_done_out,
		.multi_data_out, .multi_valid_out, .stream_data_out, .stream_valid_out,
		.stream_ready_in(stream_ready), .overrun_out);
	saq_host_model host (.clk_in, .reset_n_in, .sample_tick_in(sample_tick_out),
		.stall_in(stall), .stream_data_in(stream_data_out),
		.stream_valid_in(stream_valid_out), .stream_ready_out(stream_ready),
		.adc_data_out(adc_data), .tach0_out(tach0));
	// 20 MHz clock
	initial begin
		clk_in = 1'b0;
		forever #25 clk_in = ~clk_in;
	end
	task automatic step;
		@(posedge clk_in);
		#1;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			err_total++;
			$display("ERROR %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic near(input logic [31:0] s, input logic [31:0] e, tol);
		check(32'(s + tol >= e && s <= e + tol), 32'd1);
	endtask
	// a bounded wait that ran out ends the run at once
	task automatic bounded(input logic c);
		if (c !== 1'b1) begin
			err_total++;
			$display("ERROR %0t wait ran out", $time);
			end_sim;
		end
	endtask
	function automatic logic [31:0] lane(input int c);
		return {8'h00, 8'(c), host.cnt_reg};
	endfunction
	task automatic t_settings;
		check(32'(excite_en_out), 32'd0);
		check(32'(couple_ac_out), 32'd0);
		check(32'(rate_act_out), `SAQ_RATE_MIN_MHZ);
		gain_ten_in = 1'b1;
		excite_set_in = 4'hA;
		couple_ac_set_in = 4'h5;
		iepe_load_in = 1'b1;
		step;
		iepe_load_in = 1'b0;
		check(32'(gain_ten_out), 32'd1);
		check(32'(excite_en_out), 32'hA);
		check(32'(couple_ac_out), 32'h5);
	endtask
	task automatic rate_case(input logic [1:0] v, input logic [27:0] r,
		input logic [27:0] exp, input logic clamp);
		logic [39:0] osc;
		variant_in = v;
		rate_req_in = r;
		rate_load_in = 1'b1;
		step;
		rate_load_in = 1'b0;
		step;
		osc = 40'(exp) * (exp > `SAQ_RATE_MID_MHZ ? 256 : 512) / 1000;
		if (osc > `SAQ_TB_MAX_HZ)
			osc = `SAQ_TB_MAX_HZ;
		near(32'(rate_act_out), 32'(exp), 32'd1000);
		near(32'(osc_hz_out), osc[31:0], 32'd600);
		check(32'(rate_clamped_out), 32'(clamp));
	endtask
	task automatic t_rates;
		rate_case(2'h0, 28'h2FA_F080, 28'h2FA_F080, 1'b0);
		rate_case(2'h2, 28'h4C4_B400, 28'h4C4_B400, 1'b0);
		rate_case(2'h0, 28'h4C4_B400, `SAQ_RATE_MID_MHZ, 1'b1);
		rate_case(2'h2, 28'hBEB_C200, `SAQ_RATE_MAX_MHZ, 1'b1);
		rate_case(2'h1, 28'h000_03E8, `SAQ_RATE_MIN_MHZ, 1'b1);
	endtask
	// every channel code, the four above three must be refused
	task automatic t_single;
		for (int i = 0; i < 8; i++) begin
			single_chan_in = 3'(i);
			single_go_in = 1'b1;
			step;
			single_go_in = 1'b0;
			check(32'(single_done_out), 32'd1);
			check(32'(single_err_out), 32'(i > 3));
			check(32'(single_data_out), i > 3 ? 32'd0 : lane(i));
			step;
			check(32'(single_done_out), 32'd0);
		end
	endtask
	task automatic t_multi;
		for (int v = 0; v < 3; v++) begin
			variant_in = 2'(v);
			multi_go_in = 1'b1;
			step;
			multi_go_in = 1'b0;
			check(32'(multi_valid_out), v ? 32'h0F : 32'h1F);
			check(32'(multi_done_out), 32'd1);
			check(32'(multi_data_out[143:120]), 32'h00_1111);
			for (int c = 0; c < 4; c++)
				check(32'(multi_data_out[c*24 +: 24]), lane(c));
			if (v == 0)
				check(32'(multi_data_out[119:96]), 32'(tach0));
			step;
			check(32'(multi_done_out), 32'd0);
		end
	endtask
	// mid-run reset with variant B strapped: coupling wakes AC
	task automatic t_reset_b;
		variant_in = 2'h2;
		reset_n_in = 1'b0;
		step;
		reset_n_in = 1'b1;
		check(32'(couple_ac_out), 32'd0);
		step;
		check(32'(couple_ac_out), 32'hF);
		check(32'(excite_en_out), 32'd0);
		check(32'(rate_act_out), `SAQ_RATE_MIN_MHZ);
		check(32'(clock_run_out), 32'd0);
	endtask
	// stalled sink fills the fifo until it refuses, then drains it
	task automatic t_stream;
		rate_case(2'h2, 28'h5F5_E100, 28'h5F5_E100, 1'b0);
		scan_len_in = 3'h5;
		scan_go_in = 1'b1;
		stall = 1'b1;
		step;
		scan_go_in = 1'b0;
		clock_start_in = 1'b1;
		step;
		clock_start_in = 1'b0;
		check(32'(clock_run_out), 32'd1);
		n = 0;
		for (k = 0; k < 20000 && data_valid_out !== 1'b1; k++) begin
			n += 32'(sample_tick_out);
			step;
		end
		bounded(data_valid_out);
		check(32'(n), 32'd39);
		for (k = 0; k < 3000 && overrun_out !== 1'b1; k++)
			step;
		bounded(overrun_out);
		clock_stop_in = 1'b1;
		step;
		clock_stop_in = 1'b0;
		step;
		check(32'(clock_run_out), 32'd0);
		stall = 1'b0;
		repeat (40) step;
		check(32'(stream_valid_out), 32'd0);
		check(32'(host.rx_q.size() >= 16), 32'd1);
		for (int i = 0; i < 16; i++)
			check(32'(host.rx_q[i][26:24]), 32'(i % 5));
		check(32'(host.rx_q[1][23:16]), 32'h1);
		check(32'(host.rx_q[4][15:0] + 16'd39), 32'(host.rx_q[0][15:0]));
		scan_go_in = 1'b1;
		step;
		scan_go_in = 1'b0;
		check(32'(overrun_out), 32'd0);
	endtask
	task automatic end_sim;
		$display("mismatches %0d compares %0d", err_total, compares);
		if (err_total == 0 && compares > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	// reset held for five cycles, then the scenarios in turn
	initial begin
		{reset_n_in, gain_ten_in, iepe_load_in, rate_load_in, stall} = '0;
		{clock_start_in, clock_stop_in, single_go_in, multi_go_in} = '0;
		{scan_go_in, variant_in, excite_set_in, couple_ac_set_in} = '0;
		{rate_req_in, single_chan_in, scan_len_in} = '0;
		err_total = 0;
		compares = 0;
		repeat (5) @(posedge clk_in);
		#1 reset_n_in = 1'b1;
		t_settings;
		t_rates;
		t_single;
		t_multi;
		t_reset_b;
		t_stream;
		end_sim;
	end
endmodule // tb
bind saq_acquire_ctrl saq_acq_props props (.clk_in, .reset_n_in, .variant_in,
	.iepe_load_in, .excite_set_in, .single_go_in, .single_chan_in,
	.multi_go_in, .excite_en_out, .osc_hz_out, .rate_act_out,
	.sample_tick_out, .clock_run_out, .data_valid_out, .single_done_out,
	.single_err_out, .single_data_out, .multi_done_out, .multi_valid_out);
`default_nettype wire
